/* burst_flash_consts.svh */
// Purpose: shared constants of the burst flash host port
// Assumes: included by the package and by every design file
// Notes: guarded against double inclusion
`ifndef BURST_FLASH_CONSTS_SVH
`define BURST_FLASH_CONSTS_SVH

`define ADDR_W 21
`define DATA_W 16
`define WAIT_W 4
`define LAT_W 6
`define CMD_DEPTH 8
`define CMD_PTR_W 3

// burst read modes held in the configuration
`define MODE_CONT 2'h0
`define MODE_W8 2'h1
`define MODE_W16 2'h2
`define MODE_W32 2'h3
`define WRAP8_MASK 21'h000007
`define WRAP16_MASK 21'h00000F
`define WRAP32_MASK 21'h00001F
`define CONT_MASK 21'h1FFFFF

// continuous burst boundary every 64 words
`define BOUNDARY_LOW 6'h3F
`define GAP_CYCLES 2'h2

// program-boost pin levels
`define BOOST_LOW 2'h0
`define BOOST_HIGH 2'h1
`define BOOST_ELEV 2'h2

// configuration command sequence
`define UNLOCK1_ADDR 21'h000555
`define UNLOCK1_DATA 16'h00AA
`define UNLOCK2_ADDR 21'h0002AA
`define UNLOCK2_DATA 16'h0055
`define CFG_CMD_DATA 16'h00C0

// configuration fields carried on the address of the last cycle
`define CFG_MODE_LSB 0
`define CFG_WAIT_LSB 2
`define CFG_EDGE_BIT 6

// reset values
`define CFG_RESET_EDGE 1'h1
`define CFG_RESET_WAIT 4'h2

`endif

/* burst_flash_pkg.sv */
// Purpose: types of the burst flash host port
// Assumes: burst_flash_consts.svh gives the widths
// Notes: all module state is carried in the structs below
`include "burst_flash_consts.svh"
`default_nettype none

package burst_flash_pkg;
    typedef logic [`ADDR_W-1:0] word_addr_t;
    typedef logic [`DATA_W-1:0] word_data_t;

    typedef struct packed {
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic avs_n;
        logic bclk;
        logic guard_n;
        logic [1:0] boost;
        word_addr_t addr;
        word_data_t din;
    } pins_s;

    typedef struct packed {
        logic sync_en;
        logic rise_edge;
        logic [`WAIT_W-1:0] wait_states;
        logic [1:0] mode;
    } cfg_s;

    typedef enum logic [1:0] {ST_IDLE, ST_LAT, ST_DATA, ST_GAP} burst_e;

    typedef struct packed {
        word_addr_t addr;
        word_data_t data;
    } cmd_s;

    typedef struct packed {
        pins_s meta;
        pins_s pins;
        logic bclk_prev;
        logic we_prev;
        burst_e st;
        word_addr_t held_addr;
        word_addr_t burst_addr;
        logic [`LAT_W-1:0] lat_cnt;
        logic [1:0] gap_cnt;
        cfg_s cfg;
        logic [1:0] unlock;
        logic [`CMD_PTR_W-1:0] wptr;
        word_data_t dout;
        logic cmd_pend;
        logic cmd_valid;
    } flash_state_s;

    typedef struct packed {
        cmd_s [`CMD_DEPTH-1:0] mem;
        cmd_s rd;
    } latch_state_s;
endpackage

`default_nettype wire

/* cmd_latch_mem.sv */
// Purpose: command latches holding written command, address and data
// Assumes: one write and one read port on the same clock
// Notes: read data come out of a register one edge after rd_en
`include "burst_flash_consts.svh"
`default_nettype none

module cmd_latch_mem (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic wr_en,
    input wire logic [`CMD_PTR_W-1:0] wr_ptr,
    input wire burst_flash_pkg::cmd_s wr_entry,
    input wire logic rd_en,
    input wire logic [`CMD_PTR_W-1:0] rd_ptr,
    output var burst_flash_pkg::cmd_s rd_entry
);
    import burst_flash_pkg::*;

    latch_state_s s;
    latch_state_s n;

    always_comb begin
        n = s;
        if (wr_en) begin
            n.mem[wr_ptr] = wr_entry;
        end
        if (rd_en) begin
            n.rd = s.mem[rd_ptr];
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign rd_entry = s.rd;
endmodule

`default_nettype wire

/* burst_flash_bus_interface.sv */
// Purpose: pin-side bus interface of a 16-bit burst flash
// Assumes: pins and burst clock are asynchronous to REF_CLK; array data same clock
// Notes: burst clock edges are found by sampling, so it must be well below REF_CLK
`include "burst_flash_consts.svh"
`default_nettype none

// Function
// - 21-bit word address, 16-bit shared data
// - chip select, output enable act on levels
// - ready low when burst data invalid
// - burst clock edges advance the address
// - rising edge active unless configured otherwise
// - low strobe passes or latches address
// - high strobe ignores address inputs
// - hardware reset floats bus, ends burst
// - write guard low protects outer sectors
// - elevated boost accelerates, enters unlock bypass
// - boost low locks all sectors
// - command latches outside map feed state machine
// - advance outputs next word, ignores address
// - chip select high ends burst, floats
// - new strobe pulse restarts burst there
// - reduced variant: even start is faster
// - asynchronous reads only until configured
// - two-cycle gap at each 64-word boundary
// - linear burst wraps within aligned group
// - standard variant: odd start one extra
module burst_flash_bus_interface #(
    parameter bit REDUCED_WAIT = 1'b0
) (
    input wire logic REF_CLK,
    input wire logic RST_B,
    input wire logic CE_N,
    input wire logic OE_N,
    input wire logic WE_N,
    input wire logic ADDRESS_VALID_STROBE_N,
    input wire logic BURST_CLK,
    input wire logic WRITE_GUARD_N,
    input wire logic [1:0] PROGRAM_BOOST_INPUT,
    input wire burst_flash_pkg::word_addr_t WORD_ADDRESS_BUS,
    input wire burst_flash_pkg::word_data_t BIDIR_DATA_BUS_I,
    output logic [`DATA_W-1:0] BIDIR_DATA_BUS_O,
    output logic BIDIR_DATA_BUS_OE,
    output logic BURST_DATA_VALID,
    output logic [`ADDR_W-1:0] ARRAY_ADDR,
    input wire burst_flash_pkg::word_data_t ARRAY_DATA,
    output logic CMD_STROBE,
    output logic [`ADDR_W-1:0] CMD_ADDR,
    output logic [`DATA_W-1:0] CMD_DATA,
    output logic OUTER_GUARD,
    output logic SECTORS_LOCKED,
    output logic ACCEL_PROGRAM,
    output logic UNLOCK_BYPASS,
    output logic SYNC_MODE
);
    import burst_flash_pkg::*;

    localparam pins_s PINS_IDLE = '{
        ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, avs_n: 1'b1, bclk: 1'b0,
        guard_n: 1'b1, boost: `BOOST_HIGH, addr: '0, din: '0};
    localparam cfg_s CFG_RESET = '{
        sync_en: 1'b0, rise_edge: `CFG_RESET_EDGE, wait_states: `CFG_RESET_WAIT,
        mode: `MODE_CONT};

    flash_state_s s;
    flash_state_s n;
    cmd_s latched;
    pins_s pin_now;
    logic we_rise;
    logic act_edge;
    logic cmd_write;
    word_addr_t wr_addr;
    cmd_s wr_entry;
    logic [`CMD_PTR_W-1:0] rd_ptr;

    // next address inside the wrap group of the current mode
    function automatic word_addr_t next_burst_addr(input word_addr_t a, input logic [1:0] mode);
        word_addr_t mask;
        word_addr_t inc;
        case (mode)
            `MODE_W8: mask = `WRAP8_MASK;
            `MODE_W16: mask = `WRAP16_MASK;
            `MODE_W32: mask = `WRAP32_MASK;
            default: mask = `CONT_MASK;
        endcase
        inc = a + 1'b1;
        return (a & ~mask) | (inc & mask);
    endfunction

    // edges to wait before the first word
    function automatic logic [`LAT_W-1:0] first_latency(input logic [`WAIT_W-1:0] ws,
                                                        input logic odd);
        logic [`LAT_W-1:0] lat;
        lat = {2'h0, ws};
        lat = lat + {5'h0, odd};
        if (!REDUCED_WAIT) begin
            lat = lat + 6'h01;
        end
        return lat;
    endfunction

    always_comb begin
        pin_now = '{
            ce_n: CE_N, oe_n: OE_N, we_n: WE_N, avs_n: ADDRESS_VALID_STROBE_N,
            bclk: BURST_CLK, guard_n: WRITE_GUARD_N, boost: PROGRAM_BOOST_INPUT,
            addr: WORD_ADDRESS_BUS, din: BIDIR_DATA_BUS_I};
    end

    assign we_rise = s.pins.we_n & ~s.we_prev;
    // edge detection on the second stage only
    assign act_edge = s.cfg.rise_edge ? (s.pins.bclk & ~s.bclk_prev)
                                      : (~s.pins.bclk & s.bclk_prev);
    assign cmd_write = we_rise & ~s.pins.ce_n & s.pins.oe_n;
    assign wr_addr = s.pins.avs_n ? s.held_addr : s.pins.addr;
    assign wr_entry = '{addr: wr_addr, data: s.pins.din};
    // slot filled at the previous edge, the pointer has already moved on
    assign rd_ptr = s.wptr - 3'h1;

    always_comb begin
        n = s;
        n.meta = pin_now;
        n.pins = s.meta;
        n.bclk_prev = s.pins.bclk;
        n.we_prev = s.pins.we_n;
        n.cmd_pend = cmd_write;
        n.cmd_valid = s.cmd_pend;
        n.dout = ARRAY_DATA;
        if (!s.pins.avs_n) begin
            n.held_addr = s.pins.addr;
        end
        if (cmd_write) begin
            n.wptr = s.wptr + 1'b1;
            case (s.unlock)
                2'h0: begin
                    n.unlock = (wr_addr == `UNLOCK1_ADDR && s.pins.din == `UNLOCK1_DATA)
                               ? 2'h1 : 2'h0;
                end
                2'h1: begin
                    n.unlock = (wr_addr == `UNLOCK2_ADDR && s.pins.din == `UNLOCK2_DATA)
                               ? 2'h2 : 2'h0;
                end
                default: begin
                    n.unlock = 2'h0;
                    if (s.pins.din == `CFG_CMD_DATA) begin
                        n.cfg.sync_en = 1'b1;
                        n.cfg.mode = wr_addr[`CFG_MODE_LSB +: 2];
                        n.cfg.wait_states = wr_addr[`CFG_WAIT_LSB +: `WAIT_W];
                        n.cfg.rise_edge = wr_addr[`CFG_EDGE_BIT];
                    end
                end
            endcase
        end
        if (!s.cfg.sync_en || s.pins.ce_n) begin
            n.st = ST_IDLE;
        end else if (act_edge && s.pins.we_n && !s.pins.avs_n) begin
            n.st = ST_LAT;
            n.burst_addr = s.pins.addr;
            n.lat_cnt = first_latency(s.cfg.wait_states, s.pins.addr[0]);
        end else if (act_edge) begin
            case (s.st)
                ST_LAT: begin
                    if (s.lat_cnt == '0) begin
                        n.st = ST_DATA;
                    end else begin
                        n.lat_cnt = s.lat_cnt - 1'b1;
                    end
                end
                ST_DATA: begin
                    if (!s.pins.oe_n) begin
                        n.burst_addr = next_burst_addr(s.burst_addr, s.cfg.mode);
                        if (s.cfg.mode == `MODE_CONT &&
                            s.burst_addr[5:0] == `BOUNDARY_LOW) begin
                            n.st = ST_GAP;
                            n.gap_cnt = `GAP_CYCLES - 2'h1;
                        end
                    end
                end
                ST_GAP: begin
                    if (s.gap_cnt == 2'h0) begin
                        n.st = ST_DATA;
                    end else begin
                        n.gap_cnt = s.gap_cnt - 2'h1;
                    end
                end
                default: begin
                    n.st = ST_IDLE;
                end
            endcase
        end
    end

    // asynchronous reset is the hardware reset pin
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            s <= '{
                meta: PINS_IDLE, pins: PINS_IDLE, bclk_prev: 1'b0, we_prev: 1'b1,
                st: ST_IDLE, held_addr: '0, burst_addr: '0, lat_cnt: '0, gap_cnt: 2'h0,
                cfg: CFG_RESET, unlock: 2'h0, wptr: '0, dout: '0, cmd_pend: 1'b0,
                cmd_valid: 1'b0};
        end else begin
            s <= n;
        end
    end

    cmd_latch_mem u_cmd_latch (
        .clk(REF_CLK),
        .rst_b(RST_B),
        .wr_en(cmd_write),
        .wr_ptr(s.wptr),
        .wr_entry(wr_entry),
        .rd_en(s.cmd_pend),
        .rd_ptr(rd_ptr),
        .rd_entry(latched)
    );

    always_comb begin
        if (s.cfg.sync_en) begin
            ARRAY_ADDR = s.burst_addr;
        end else begin
            ARRAY_ADDR = s.pins.avs_n ? s.held_addr : s.pins.addr;
        end
        // levels of select and enable gate the bus directly
        BIDIR_DATA_BUS_OE = ~s.pins.ce_n & ~s.pins.oe_n & s.pins.we_n &
                            (s.cfg.sync_en ? (s.st == ST_DATA) : 1'b1);
        BURST_DATA_VALID = ~(s.st == ST_LAT || s.st == ST_GAP);
    end

    assign BIDIR_DATA_BUS_O = s.dout;
    assign CMD_STROBE = s.cmd_valid;
    assign CMD_ADDR = latched.addr;
    assign CMD_DATA = latched.data;
    assign OUTER_GUARD = ~s.pins.guard_n;
    assign SECTORS_LOCKED = s.pins.boost == `BOOST_LOW;
    assign ACCEL_PROGRAM = s.pins.boost == `BOOST_ELEV;
    assign UNLOCK_BYPASS = s.pins.boost == `BOOST_ELEV;
    assign SYNC_MODE = s.cfg.sync_en;

    a_reset_floats: assert property (
        @(posedge REF_CLK) $rose(RST_B) |-> !BIDIR_DATA_BUS_OE && s.st == ST_IDLE)
        else $error("bus driven right after reset");

    a_latency_not_ready: assert property (
        @(posedge REF_CLK) disable iff (!RST_B)
        (s.st == ST_LAT) |-> !BURST_DATA_VALID && !BIDIR_DATA_BUS_OE)
        else $error("ready or data during initial latency");

    a_async_only_first: assert property (
        @(posedge REF_CLK) disable iff (!RST_B)
        !s.cfg.sync_en |-> s.st == ST_IDLE)
        else $error("burst state before configuration");

    a_select_ends_burst: assert property (
        @(posedge REF_CLK) disable iff (!RST_B)
        s.pins.ce_n |-> !BIDIR_DATA_BUS_OE ##1 s.st == ST_IDLE)
        else $error("burst survived deselect");

    a_cont_advance: assert property (
        @(posedge REF_CLK) disable iff (!RST_B)
        (s.st == ST_DATA && act_edge && !s.pins.oe_n && !s.pins.ce_n && s.pins.avs_n &&
         s.cfg.mode == `MODE_CONT && s.burst_addr[5:0] != `BOUNDARY_LOW)
        |=> s.st == ST_DATA && s.burst_addr == $past(s.burst_addr) + 21'h000001)
        else $error("continuous burst did not advance by one");

    a_wrap_in_group: assert property (
        @(posedge REF_CLK) disable iff (!RST_B)
        (s.st == ST_DATA && act_edge && !s.pins.oe_n && !s.pins.ce_n && s.pins.avs_n &&
         s.cfg.mode == `MODE_W8)
        |=> s.burst_addr[20:3] == $past(s.burst_addr[20:3]) &&
            s.burst_addr[2:0] == $past(s.burst_addr[2:0]) + 3'h1)
        else $error("linear burst left its group");

    a_strobe_high_holds: assert property (
        @(posedge REF_CLK) disable iff (!RST_B)
        !s.cfg.sync_en && s.pins.avs_n && $past(s.pins.avs_n) |-> $stable(s.held_addr))
        else $error("address taken while strobe high");

    a_guard_outer: assert property (
        @(posedge REF_CLK) disable iff (!RST_B)
        (!WRITE_GUARD_N)[*3] |-> OUTER_GUARD)
        else $error("outer sectors not guarded");

    a_boost_locks: assert property (
        @(posedge REF_CLK) disable iff (!RST_B)
        (PROGRAM_BOOST_INPUT == `BOOST_LOW)[*3] |-> SECTORS_LOCKED && !ACCEL_PROGRAM)
        else $error("sectors not locked with boost low");

    a_cmd_latched: assert property (
        @(posedge REF_CLK) disable iff (!RST_B)
        cmd_write |-> ##2 CMD_STROBE && CMD_DATA == $past(s.pins.din, 2))
        else $error("command latch lost a write");

    a_odd_extra: assert property (
        @(posedge REF_CLK) disable iff (!RST_B)
        (s.st != ST_LAT && !s.pins.ce_n && n.st == ST_LAT)
        |=> s.lat_cnt == {2'h0, s.cfg.wait_states} + {5'h0, s.burst_addr[0]}
                         + {5'h0, !REDUCED_WAIT})
        else $error("wrong initial latency");

    a_boundary_gap: assert property (
        @(posedge REF_CLK) disable iff (!RST_B)
        (s.st == ST_DATA && act_edge && !s.pins.oe_n && !s.pins.ce_n && s.pins.avs_n &&
         s.cfg.mode == `MODE_CONT && s.burst_addr[5:0] == `BOUNDARY_LOW)
        |=> s.st == ST_GAP && !BURST_DATA_VALID && s.gap_cnt == 2'h1)
        else $error("no gap at 64-word boundary");
endmodule

`default_nettype wire

/* flash_host_model.sv */
// Purpose: host controller model driving the flash pins
// Assumes: clk is REF_CLK; one burst clock period is 8 cycles (200 ns)
// Notes: released data lines show the inverse of the last driven word
`include "burst_flash_consts.svh"
`default_nettype none

module flash_host_model (
    input wire logic clk,
    output var burst_flash_pkg::pins_s pin
);
    timeunit 1ns;
    timeprecision 1ps;
    import burst_flash_pkg::*;

    initial begin
        pin = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, `BOOST_HIGH, '0, '0};
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask

    task automatic set_level(input logic g, input logic [1:0] b);
        tick(1);
        pin.guard_n = g;
        pin.boost = b;
    endtask

    task automatic idle();
        tick(1);
        pin.ce_n = 1'b1;
        pin.oe_n = 1'b1;
        pin.avs_n = 1'b1;
    endtask

    task automatic drive_read(input word_addr_t a, input logic avs);
        tick(1);
        pin.ce_n = 1'b0;
        pin.oe_n = 1'b0;
        pin.we_n = 1'b1;
        pin.addr = a;
        pin.avs_n = avs;
    endtask

    // returns with the write strobe raised; data held until end_write
    task automatic write_cmd(input word_addr_t a, input word_data_t d);
        tick(1);
        pin.ce_n = 1'b0;
        pin.oe_n = 1'b1;
        pin.avs_n = 1'b0;
        pin.bclk = 1'b0;
        pin.addr = a;
        pin.din = d;
        tick(2);
        pin.we_n = 1'b0;
        tick(3);
        pin.we_n = 1'b1;
    endtask

    task automatic end_write();
        tick(2);
        pin.ce_n = 1'b1;
        pin.avs_n = 1'b1;
        pin.din = ~pin.din;
    endtask

    // one burst clock period, active edge first
    task automatic step(input logic act);
        pin.bclk = act;
        tick(4);
        pin.bclk = ~act;
        tick(4);
    endtask

    task automatic load(input word_addr_t a, input logic act);
        tick(1);
        pin.ce_n = 1'b0;
        pin.we_n = 1'b1;
        pin.oe_n = 1'b0;
        pin.avs_n = 1'b0;
        pin.addr = a;
        pin.bclk = ~act;
        tick(2);
        step(act);
        pin.avs_n = 1'b1;
        pin.addr = ~a;
    endtask
endmodule

`default_nettype wire

/* burst_flash_bus_interface_tb.sv */
// Purpose: self-checking bench of the burst flash host port
// Assumes: REF_CLK 40 MHz; burst clock from the host model
// Notes: array words come from a fixed address hash; standard variant
`include "burst_flash_consts.svh"
`default_nettype none

module burst_flash_bus_interface_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import burst_flash_pkg::*;

    localparam int WAIT = 2;
    logic clk;
    logic rst_b;
    pins_s pin;
    word_data_t data_i;
    word_data_t arr_data;
    logic [`DATA_W-1:0] data_o;
    logic [`DATA_W-1:0] cmd_data;
    logic [`ADDR_W-1:0] arr_addr;
    logic [`ADDR_W-1:0] cmd_addr;
    logic oe;
    logic rdy;
    logic cmd_strobe;
    logic guard;
    logic locked;
    logic accel;
    logic bypass;
    logic sync;
    int err_total = 0;
    int n_tests = 0;
    int cyc = 0;
    int seed = 32'hA39681FA;
    word_addr_t ra;
    word_addr_t rb;

    function automatic word_data_t arr(input word_addr_t a);
        return a[15:0] ^ 16'hC35A ^ 16'(a[20:16]);
    endfunction

    assign arr_data = arr(arr_addr);
    assign data_i = oe ? data_o : pin.din;

    flash_host_model u_host (.clk(clk), .pin(pin));

    burst_flash_bus_interface u_burst_flash_bus_interface (
        .REF_CLK(clk), .RST_B(rst_b), .CE_N(pin.ce_n), .OE_N(pin.oe_n),
        .WE_N(pin.we_n), .ADDRESS_VALID_STROBE_N(pin.avs_n), .BURST_CLK(pin.bclk),
        .WRITE_GUARD_N(pin.guard_n), .PROGRAM_BOOST_INPUT(pin.boost),
        .WORD_ADDRESS_BUS(pin.addr), .BIDIR_DATA_BUS_I(data_i),
        .BIDIR_DATA_BUS_O(data_o), .BIDIR_DATA_BUS_OE(oe), .BURST_DATA_VALID(rdy),
        .ARRAY_ADDR(arr_addr), .ARRAY_DATA(arr_data), .CMD_STROBE(cmd_strobe),
        .CMD_ADDR(cmd_addr), .CMD_DATA(cmd_data), .OUTER_GUARD(guard),
        .SECTORS_LOCKED(locked), .ACCEL_PROGRAM(accel), .UNLOCK_BYPASS(bypass),
        .SYNC_MODE(sync)
    );

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            err_total++;
            wrap_up();
        end
    end

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask

    task automatic wr(input word_addr_t a, input word_data_t d);
        u_host.write_cmd(a, d);
        for (int k = 0; k < 10 && cmd_strobe !== 1'b1; k++) settle(1);
        check("cmd strobe", cmd_strobe, 1'b1);
        check("cmd addr", cmd_addr, a);
        check("cmd data", cmd_data, d);
        u_host.end_write();
    endtask

    task automatic configure(input logic [1:0] md, input logic act);
        wr(`UNLOCK1_ADDR, `UNLOCK1_DATA);
        wr(`UNLOCK2_ADDR, `UNLOCK2_DATA);
        wr(word_addr_t'({act, 4'(WAIT), md}), `CFG_CMD_DATA);
        settle(4);
        check("sync mode", sync, 1'b1);
    endtask

    // expected per period: -1 for ready low, else the word address shown
    task automatic burst(input logic act, input logic [1:0] md, input word_addr_t a,
                         input int n);
        int exp_q[$];
        word_addr_t cur;
        word_addr_t mask;
        cur = a;
        mask = md == `MODE_W8 ? `WRAP8_MASK : md == `MODE_W16 ? `WRAP16_MASK :
               md == `MODE_W32 ? `WRAP32_MASK : `CONT_MASK;
        repeat (WAIT + 2 + a[0]) exp_q.push_back(-1);
        while (exp_q.size() < n) begin
            exp_q.push_back(int'(cur));
            if (md == `MODE_CONT && cur[5:0] == `BOUNDARY_LOW) begin
                exp_q.push_back(-1);
                exp_q.push_back(-1);
            end
            cur = (cur & ~mask) | ((cur + 1'b1) & mask);
        end
        u_host.load(a, act);
        for (int i = 0; i < n; i++) begin
            if (i > 0) u_host.step(act);
            check("ready", rdy, exp_q[i] >= 0);
            if (exp_q[i] >= 0) begin
                check("burst oe", oe, 1'b1);
                check("burst word", data_o, arr(word_addr_t'(exp_q[i])));
            end
        end
    endtask

    initial begin
        rst_b = 1'b0;
        settle(1);
        check("reset oe", oe, 1'b0);
        check("reset ready", rdy, 1'b1);
        check("reset strobe", cmd_strobe, 1'b0);
        settle(2);
        rst_b = 1'b1;
        settle(3);
        for (int i = 0; i < 6; i++) begin
            u_host.set_level(i[0], 2'(i / 2));
            settle(4);
            check("outer guard", guard, !i[0]);
            check("locked", locked, i / 2 == 0);
            check("accel", accel, i / 2 == 2);
            check("bypass", bypass, i / 2 == 2);
        end
        u_host.set_level(1'b1, `BOOST_HIGH);
        ra = word_addr_t'($random(seed));
        u_host.drive_read(ra, 1'b0);
        settle(5);
        check("read oe", oe, 1'b1);
        check("read addr", arr_addr, ra);
        check("read data", data_o, arr(ra));
        rb = word_addr_t'($random(seed));
        u_host.drive_read(rb, 1'b0);
        settle(4);
        u_host.drive_read(rb, 1'b1);
        settle(4);
        u_host.drive_read(~rb, 1'b1);
        settle(5);
        check("held addr", arr_addr, rb);
        check("held data", data_o, arr(rb));
        u_host.idle();
        settle(5);
        check("standby oe", oe, 1'b0);
        wr(word_addr_t'($random(seed)), word_data_t'($random(seed)));
        configure(`MODE_CONT, 1'b1);
        u_host.drive_read(ra, 1'b0);
        settle(5);
        check("async refused", oe, 1'b0);
        burst(1'b1, `MODE_CONT, 21'h00003C, 12);
        burst(1'b1, `MODE_CONT, 21'h000017, 7);
        rst_b = 1'b0;
        settle(2);
        check("abort oe", oe, 1'b0);
        check("abort sync", sync, 1'b0);
        u_host.idle();
        rst_b = 1'b1;
        settle(3);
        configure(`MODE_W8, 1'b0);
        burst(1'b0, `MODE_W8, 21'h000039, 14);
        for (int m = 2; m < 4; m++) begin
            configure(2'(m), 1'b1);
            burst(1'b1, 2'(m), word_addr_t'($random(seed)), 10);
        end
        u_host.idle();
        settle(5);
        check("end oe", oe, 1'b0);
        wrap_up();
    end
endmodule

`default_nettype wire
